// ---- rtl/otp_prog_pkg.sv ----
/*
  Constants, state codes and carrier types for the one-time-programmable
  byte programmer. Assumes a single 200 MHz clock and a byte-wide device.
*/
package otp_prog_pkg;
  // Clock
  localparam int CLK_MHZ = 200;
  localparam int CLK_PERIOD_NS = 5;
  // Device geometry
  localparam int ADDR_W = 15;
  localparam int DATA_W = 8;
  localparam logic [14:0] ADDR_LAST_DEF = 15'h7fff;
  // Program pulse, nominal and window
  localparam int PULSE_US = 100;
  localparam int PULSE_MIN_US = 95;
  localparam int PULSE_MAX_US = 105;
  localparam int PULSE_CYC = PULSE_US * CLK_MHZ;
  localparam int PULSE_MIN_CYC = PULSE_MIN_US * CLK_MHZ;
  localparam int PULSE_MAX_CYC = PULSE_MAX_US * CLK_MHZ;
  // Address, data, supply setup and data hold
  localparam int SETUP_US = 2;
  localparam int SETUP_CYC = SETUP_US * CLK_MHZ;
  // Data valid after drive enable, and release after disable (least waits)
  localparam int DATA_DELAY_NS = 150;
  localparam int DATA_DELAY_CYC = (DATA_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RELEASE_NS = 130;
  localparam int RELEASE_CYC = (RELEASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Retries and widths
  localparam logic [3:0] MAX_RETRY = 4'ha;
  localparam int TMR_W = 16;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_RAMP = 4'h1,
    S_SETUP = 4'h3,
    S_PULSE = 4'h2,
    S_HOLD = 4'h6,
    S_VREAD = 4'h7,
    S_VFLOAT = 4'h5,
    S_DOWN = 4'h4,
    S_END = 4'hc
  } state_t;

  typedef enum logic [1:0] {
    PH_FIRST = 2'h0,
    PH_VERIFY = 2'h1,
    PH_FINAL = 2'h3,
    PH_ID = 2'h2
  } phase_t;

  // Everything the programmer drives toward the device
  typedef struct packed {
    logic [14:0] addr;
    logic [7:0] data;
    logic data_oe_n;
    logic ce_n;
    logic oe_n;
    logic vcc_prog;
    logic vpp_prog;
    logic id_select_line;
  } dev_pins_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic pass;
    logic fail;
    logic id_valid;
  } status_t;

  localparam dev_pins_t PINS_RST = '{addr: 15'h0, data: 8'h0, data_oe_n: 1'b1,
    ce_n: 1'b1, oe_n: 1'b1, vcc_prog: 1'b0, vpp_prog: 1'b0, id_select_line: 1'b0};
endpackage : otp_prog_pkg

// ---- rtl/prog_timer.sv ----
/*
  Down counter that times each step of the programmer.
  Assumes load is a one-cycle request from the sequencer.
*/
`timescale 1ns/10ps
module prog_timer (
  input wire logic clk,
  input wire logic nrst,
  input wire logic load,
  input wire logic [15:0] val,
  output logic zero
);
  logic [15:0] count;

  // Load val-1 so that a step lasts exactly val cycles
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count <= 16'h0;
    end else if (load) begin
      count <= val - 16'h1;
    end else if (count != 16'h0) begin
      count <= count - 16'h1;
    end
  end

  assign zero = (count == 16'h0);
endmodule : prog_timer

// ---- rtl/source_mem.sv ----
/*
  Source image for the device: one write port for loading, one
  registered read port for the sequencer. Assumes synchronous writes.
*/
`timescale 1ns/10ps
module source_mem (
  input wire logic clk,
  input wire logic we,
  input wire logic [14:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic [14:0] raddr,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:32767];

  // Write and registered read
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule : source_mem

// ---- rtl/otp_programmer.sv ----
/*
  Programmer for a byte-wide one-time-programmable memory: first pass of
  single pulses, verify and reprogram loop, final read at normal supplies,
  and identification read. Assumes the source image is loaded before
  start, and that supply switches and the high-voltage id line follow
  the level outputs.
*/
// Notes on behaviour
// - Each program pulse holds the chip select low for 100 us, inside 95 to 105 us.
// - The address starts at the first location before the first pulse.
// - Core and program supplies are raised before any pulse and lowered after the verify loop.
// - The first pass gives each address one pulse with no read-back.
// - A verify and reprogram loop then visits every address in turn.
// - A failing byte gets up to ten further pulses, each followed by a read-back.
// - A byte still wrong after ten retries fails the whole part.
// - A byte that verifies moves the loop to the next address, until all are checked.
// - If the verify loop passed, every byte is read at read-level supplies and compared for the verdict.
// - Data is sampled no sooner than 150 ns after drive enable and not driven until 130 ns after release.
// - Identification raises the id line and reads the maker code at low bit 0, device code at 1.
`timescale 1ns/10ps
module otp_programmer #(
  parameter int PULSE_CYCLES = otp_prog_pkg::PULSE_CYC,
  parameter logic [14:0] ADDR_LAST = otp_prog_pkg::ADDR_LAST_DEF
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic start,
  input wire logic id_start,
  input wire logic load_we,
  input wire logic [14:0] load_addr,
  input wire logic [7:0] load_data,
  input wire logic [7:0] dev_data_in,
  output otp_prog_pkg::dev_pins_t pins,
  output otp_prog_pkg::status_t status,
  output logic [7:0] maker_code,
  output logic [7:0] device_code
);
  import otp_prog_pkg::*;

  state_t state, next_state;
  phase_t phase, next_phase;
  logic [14:0] addr, next_addr;
  logic [3:0] retry, next_retry;
  logic mism, next_mism;
  logic tmr_load, tmr_zero;
  logic [15:0] tmr_val;
  logic [7:0] src_data, rd_data;
  logic match, strobe;

  prog_timer u_timer (
    .clk(clk),
    .nrst(nrst),
    .load(tmr_load),
    .val(tmr_val),
    .zero(tmr_zero)
  );

  source_mem u_mem (
    .clk(clk),
    .we(load_we),
    .waddr(load_addr),
    .wdata(load_data),
    .raddr(addr),
    .rdata(src_data)
  );

  function automatic logic [15:0] cyc(input int n);
    cyc = n[15:0];
  endfunction : cyc

  function automatic logic is_write(input state_t s);
    is_write = (s == S_SETUP) || (s == S_PULSE) || (s == S_HOLD);
  endfunction : is_write

  assign match = (rd_data == src_data);
  assign strobe = (state == S_VREAD) && tmr_zero;

  // Sequencer next state; each timed step loads the timer as it is entered
  always_comb begin
    next_state = state;
    next_phase = phase;
    next_addr = addr;
    next_retry = retry;
    next_mism = mism;
    tmr_load = 1'b0;
    tmr_val = 16'h0;
    case (state)
      S_IDLE: begin
        if (start || id_start) begin
          next_state = S_RAMP;
          next_phase = start ? PH_FIRST : PH_ID;
          next_addr = 15'h0;
          next_mism = 1'b0;
          tmr_load = 1'b1;
          tmr_val = cyc(SETUP_CYC);
        end
      end
      S_RAMP: begin
        if (tmr_zero) begin
          tmr_load = 1'b1;
          if (phase == PH_ID) begin
            next_state = S_VREAD;
            tmr_val = cyc(DATA_DELAY_CYC);
          end else begin
            next_state = S_SETUP;
            tmr_val = cyc(SETUP_CYC);
          end
        end
      end
      S_SETUP: begin
        if (tmr_zero) begin
          next_state = S_PULSE;
          tmr_load = 1'b1;
          tmr_val = cyc(PULSE_CYCLES);
        end
      end
      S_PULSE: begin
        if (tmr_zero) begin
          next_state = S_HOLD;
          tmr_load = 1'b1;
          tmr_val = cyc(SETUP_CYC);
        end
      end
      S_HOLD: begin
        if (tmr_zero) begin
          tmr_load = 1'b1;
          if (phase == PH_FIRST && addr != ADDR_LAST) begin
            next_state = S_SETUP;
            next_addr = addr + 15'h1;
            tmr_val = cyc(SETUP_CYC);
          end else begin
            if (phase == PH_FIRST) begin
              next_phase = PH_VERIFY;
              next_addr = 15'h0;
            end
            next_state = S_VREAD;
            tmr_val = cyc(DATA_DELAY_CYC);
          end
        end
      end
      S_VREAD: begin
        if (tmr_zero) begin
          next_state = S_VFLOAT;
          tmr_load = 1'b1;
          tmr_val = cyc(RELEASE_CYC);
        end
      end
      S_VFLOAT: begin
        if (tmr_zero) begin
          tmr_load = 1'b1;
          tmr_val = cyc(DATA_DELAY_CYC);
          case (phase)
            PH_ID: begin
              if (!addr[0]) begin
                next_addr = 15'h1;
                next_state = S_VREAD;
              end else begin
                next_state = S_END;
              end
            end
            PH_FINAL: begin
              next_mism = mism | !match;
              if (addr == ADDR_LAST) begin
                next_state = S_END;
              end else begin
                next_addr = addr + 15'h1;
                next_state = S_VREAD;
              end
            end
            default: begin
              if (match) begin
                if (addr == ADDR_LAST) begin
                  next_state = S_DOWN;
                  tmr_val = cyc(SETUP_CYC);
                end else begin
                  next_addr = addr + 15'h1;
                  next_state = S_VREAD;
                end
              end else if (retry == MAX_RETRY) begin
                next_mism = 1'b1;
                next_state = S_DOWN;
                tmr_val = cyc(SETUP_CYC);
              end else begin
                next_retry = retry + 4'h1;
                next_state = S_SETUP;
                tmr_val = cyc(SETUP_CYC);
              end
            end
          endcase
        end
      end
      S_DOWN: begin
        if (tmr_zero) begin
          if (mism) begin
            next_state = S_END;
          end else begin
            next_state = S_VREAD;
            next_phase = PH_FINAL;
            next_addr = 15'h0;
            tmr_load = 1'b1;
            tmr_val = cyc(DATA_DELAY_CYC);
          end
        end
      end
      S_END: begin
        next_state = S_IDLE;
      end
      default: begin
        next_state = S_IDLE;
      end
    endcase
  end

  // Sequencer registers; retry clears whenever the address moves
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= S_IDLE;
      phase <= PH_FIRST;
      addr <= 15'h0;
      retry <= 4'h0;
      mism <= 1'b0;
    end else begin
      state <= next_state;
      phase <= next_phase;
      addr <= next_addr;
      retry <= (next_addr != addr || state == S_IDLE) ? 4'h0 : next_retry;
      mism <= next_mism;
    end
  end

  // Read-back capture after the full drive-to-data delay
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_data <= 8'h0;
      maker_code <= 8'h0;
      device_code <= 8'h0;
    end else if (strobe) begin
      rd_data <= dev_data_in;
      if (phase == PH_ID && !addr[0]) begin
        maker_code <= dev_data_in;
      end
      if (phase == PH_ID && addr[0]) begin
        device_code <= dev_data_in;
      end
    end
  end

  // Device pins, registered from the next step
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pins <= PINS_RST;
    end else begin
      pins.addr <= next_addr;
      pins.data <= src_data;
      pins.data_oe_n <= !is_write(next_state);
      pins.ce_n <= (next_state != S_PULSE);
      pins.oe_n <= (next_state != S_VREAD);
      pins.vcc_prog <= next_phase inside {PH_FIRST, PH_VERIFY} && !(next_state inside {S_IDLE, S_DOWN, S_END});
      pins.vpp_prog <= next_phase inside {PH_FIRST, PH_VERIFY} && !(next_state inside {S_IDLE, S_DOWN, S_END});
      pins.id_select_line <= (next_phase == PH_ID) && !(next_state inside {S_IDLE, S_END});
    end
  end

  // Status flags other than busy held until the next run starts
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      status <= '0;
    end else begin
      status.busy <= (next_state != S_IDLE);
      if (state == S_IDLE && (start || id_start)) begin
        status.done <= 1'b0;
        status.pass <= 1'b0;
        status.fail <= 1'b0;
        status.id_valid <= 1'b0;
      end else if (next_state == S_END && state != S_END) begin
        if (phase == PH_ID) begin
          status.id_valid <= 1'b1;
        end else begin
          status.done <= 1'b1;
          status.pass <= !next_mism;
          status.fail <= next_mism;
        end
      end
    end
  end

  // Helper counters for the checks below
  logic [15:0] ce_low_cnt, oe_low_cnt;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ce_low_cnt <= 16'h0;
      oe_low_cnt <= 16'h0;
    end else begin
      ce_low_cnt <= pins.ce_n ? 16'h0 : ce_low_cnt + 16'h1;
      oe_low_cnt <= pins.oe_n ? 16'h0 : oe_low_cnt + 16'h1;
    end
  end

  sequence verify_fail_last;
    state == S_VFLOAT && tmr_zero && phase == PH_VERIFY && !match && retry == MAX_RETRY;
  endsequence
  sequence verify_fail_retry;
    state == S_VFLOAT && tmr_zero && phase == PH_VERIFY && !match && retry != MAX_RETRY;
  endsequence
  sequence verify_pass_next;
    state == S_VFLOAT && tmr_zero && phase == PH_VERIFY && match && addr != ADDR_LAST;
  endsequence

  a_pulse_width: assert property (@(posedge clk) disable iff (!nrst)
    $rose(pins.ce_n) |-> ce_low_cnt == cyc(PULSE_CYCLES)) else $error("program pulse width wrong");
  a_start_addr_zero: assert property (@(posedge clk) disable iff (!nrst)
    (state == S_RAMP && tmr_zero && phase == PH_FIRST) |=> ##1 pins.addr == 15'h0 && state == S_SETUP)
    else $error("programming did not start at address zero");
  a_supply_in_pulse: assert property (@(posedge clk) disable iff (!nrst)
    !pins.ce_n |-> pins.vcc_prog && pins.vpp_prog) else $error("pulse without program supplies");
  a_first_no_read: assert property (@(posedge clk) disable iff (!nrst)
    (phase == PH_FIRST && state != S_IDLE) |-> pins.oe_n) else $error("read during first pass");
  a_verify_entry: assert property (@(posedge clk) disable iff (!nrst)
    (state == S_HOLD && tmr_zero && phase == PH_FIRST && addr == ADDR_LAST)
    |=> phase == PH_VERIFY && addr == 15'h0 ##1 !pins.oe_n) else $error("verify loop not entered at zero");
  a_retry_step: assert property (@(posedge clk) disable iff (!nrst)
    verify_fail_retry |=> state == S_SETUP && retry == $past(retry) + 4'h1) else $error("retry not counted");
  a_retry_give_up: assert property (@(posedge clk) disable iff (!nrst)
    verify_fail_last |=> state == S_DOWN && mism) else $error("failed byte not abandoned");
  a_verify_advance: assert property (@(posedge clk) disable iff (!nrst)
    verify_pass_next |=> addr == $past(addr) + 15'h1 && retry == 4'h0 ##1 pins.addr == addr)
    else $error("verify loop did not advance");
  a_final_low_supply: assert property (@(posedge clk) disable iff (!nrst)
    (phase == PH_FINAL && !pins.oe_n) |-> !pins.vcc_prog && !pins.vpp_prog) else $error("final read at high supply");
  a_pass_exclusive: assert property (@(posedge clk) disable iff (!nrst)
    $rose(status.pass) |-> !status.fail && $past(phase) == PH_FINAL) else $error("pass without final read");
  a_data_valid_wait: assert property (@(posedge clk) disable iff (!nrst)
    strobe |-> oe_low_cnt == cyc(DATA_DELAY_CYC - 1)) else $error("sampled before drive delay");
  a_release_wait: assert property (@(posedge clk) disable iff (!nrst)
    $rose(pins.oe_n) |-> pins.data_oe_n [*8]) else $error("drove data before release");
  a_id_line_read: assert property (@(posedge clk) disable iff (!nrst)
    (phase == PH_ID && !pins.oe_n) |-> pins.id_select_line && !pins.vpp_prog) else $error("id read without id line");
  a_retry_clear: assert property (@(posedge clk) disable iff (!nrst)
    (addr != $past(addr)) |-> retry == 4'h0) else $error("retry not cleared on address change");
endmodule : otp_programmer

// ---- verif/otp_dev_model.sv ----
/*
  Behavioural model of the byte-wide one-time-programmable device: four cells,
  program pulses, delayed read drive and identification codes.
  Assumes the bench resolves the shared data wire from pins and q.
*/
`timescale 1ns/10ps
module otp_dev_model #(
  parameter real PW_NS = 100.0,
  parameter int DATA_NS = 145,
  parameter int TDF_NS = 125,
  parameter logic [7:0] MAKER_CODE = 8'h5a, // Arbitrary value
  parameter logic [7:0] DEVICE_CODE = 8'ha5 // Arbitrary value
) (
  input otp_prog_pkg::dev_pins_t pins,
  input wire logic wipe,
  input wire logic [14:0] weak_addr,
  input wire logic [7:0] weak_need,
  input wire logic corrupt_final,
  output logic [7:0] q,
  output int errs
);
  import otp_prog_pkg::*;
  logic [7:0] mem [0:3];
  int pulses [0:3];
  int seq [$];
  realtime t_fall = -1.0;
  logic driving;

  // Cell or code seen on the data pins
  function automatic logic [7:0] cell_value();
    if (pins.id_select_line) return pins.addr[0] ? DEVICE_CODE : MAKER_CODE;
    if (corrupt_final && !pins.vcc_prog) return mem[pins.addr[1:0]] ^ 8'h01;
    return mem[pins.addr[1:0]];
  endfunction : cell_value

  // Blank cells between scenarios
  initial errs = 0;
  always @(posedge wipe) begin
    foreach (mem[i]) begin
      mem[i] = 8'hff;
      pulses[i] = 0;
    end
    seq.delete();
  end

  // Program pulse: checked, counted, burnt once enough pulses arrived
  always @(negedge pins.ce_n) t_fall = $realtime;
  always @(posedge pins.ce_n) begin
    if (t_fall >= 0.0) begin
      if ($realtime - t_fall < PW_NS * 0.95 || $realtime - t_fall > PW_NS * 1.05) errs++;
      if (!pins.vcc_prog || !pins.vpp_prog || pins.data_oe_n || pins.addr > 15'h3) errs++;
      seq.push_back(int'(pins.addr));
      pulses[pins.addr[1:0]]++;
      if (pulses[pins.addr[1:0]] >= ((pins.addr == weak_addr) ? int'(weak_need) : 1)) begin
        mem[pins.addr[1:0]] = mem[pins.addr[1:0]] & pins.data;
      end
      t_fall = -1.0;
    end
  end

  // Read drive: garbage until valid, value while enabled, short hold, then released
  initial begin
    q = 8'h00;
    driving = 1'b0;
    forever begin
      @(negedge pins.oe_n);
      driving = 1'b1;
      q = ~q;
      #(DATA_NS);
      while (!pins.oe_n) begin
        q = cell_value();
        #1;
      end
      #(TDF_NS);
      driving = 1'b0;
      q = ~q;
    end
  end

  // Both parties driving the data pins at once
  always @(pins.data_oe_n, driving) if (driving && pins.data_oe_n === 1'b0) errs++;
endmodule : otp_dev_model

// ---- verif/otp_byte_program_sequencer_tb.sv ----
/*
  Self-checking bench for the programmer: identification read, program runs
  with weak bytes, retry limit, failed part and failed final read.
  Assumes the device model in otp_dev_model and a 200 MHz clock.
*/
`timescale 1ns/10ps
module otp_byte_program_sequencer_tb;
  import otp_prog_pkg::*;
  localparam logic [7:0] MAKER = 8'h5a; // Arbitrary value
  localparam logic [7:0] DEVICE = 8'ha5; // Arbitrary value
  logic clk, nrst, start, id_start, load_we, wipe, corrupt_final;
  logic [14:0] load_addr, weak_addr;
  logic [7:0] load_data, dev_data_in, maker_code, device_code, weak_need, q;
  dev_pins_t pins;
  status_t status, prev;
  int bad_count, check_count, dev_errs;
  logic [15:0] lfsr;
  logic [15:0] expq [$];

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Shared data wire
  assign dev_data_in = (pins.data_oe_n === 1'b0) ? pins.data : q;

  otp_programmer #(.PULSE_CYCLES(20), .ADDR_LAST(15'h3)) i_dut (.clk(clk), .nrst(nrst), .start(start),
    .id_start(id_start), .load_we(load_we), .load_addr(load_addr), .load_data(load_data),
    .dev_data_in(dev_data_in), .pins(pins), .status(status), .maker_code(maker_code),
    .device_code(device_code));
  otp_dev_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE)) i_dev (.pins(pins), .wipe(wipe),
    .weak_addr(weak_addr), .weak_need(weak_need), .corrupt_final(corrupt_final), .q(q), .errs(dev_errs));

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check

  task automatic results();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : results

  // Completion watcher: compare with the oldest note
  always @(posedge clk) begin
    prev <= status;
    if ((status.done && !prev.done) || (status.id_valid && !prev.id_valid)) begin
      if (expq.size() == 0) check(16'hffff, 16'h0000);
      else if (status.done) check({14'h0, status.pass, status.fail}, expq.pop_front());
      else check({maker_code, device_code}, expq.pop_front());
    end
  end

  // Start a run, poke a refused id request, wait for idle
  task automatic run(input logic is_id, input logic [15:0] exp);
    int n;
    n = 0;
    expq.push_back(exp);
    @(posedge clk);
    #1;
    if (is_id) id_start = 1'b1;
    else start = 1'b1;
    @(posedge clk);
    #1;
    start = 1'b0;
    id_start = 1'b0;
    check({15'h0, status.busy}, 16'h0001);
    repeat (8) @(posedge clk);
    #1 id_start = 1'b1;
    @(posedge clk);
    #1 id_start = 1'b0;
    while (status.busy !== 1'b0 && n < 20000) begin
      @(posedge clk);
      n++;
    end
    if (n >= 20000) begin
      bad_count++;
      results();
    end
    @(posedge clk);
    check(16'(dev_errs), 16'h0);
    check(16'(expq.size()), 16'h0);
  endtask : run

  // Program run with one weak byte needing a given number of pulses
  task automatic burn_run(input logic [14:0] waddr, input int need, input logic corrupt);
    int exps [$];
    logic [7:0] img [0:3];
    logic fail;
    wipe = 1'b1;
    weak_addr = waddr;
    weak_need = 8'(need);
    corrupt_final = corrupt;
    for (int a = 0; a <= 3; a++) begin
      lfsr = lfsr_next(lfsr);
      @(posedge clk);
      #1;
      load_we = 1'b1;
      load_addr = 15'(a);
      load_data = lfsr[7:0] & 8'h7f;
      img[a] = lfsr[7:0] & 8'h7f;
      exps.push_back(a);
    end
    @(posedge clk);
    #1;
    load_we = 1'b0;
    wipe = 1'b0;
    for (int r = 1; r < need && r <= 10; r++) exps.push_back(int'(waddr));
    fail = (need > 11) || corrupt;
    run(1'b0, {14'h0, !fail, fail});
    check(16'(i_dev.seq.size()), 16'(exps.size()));
    foreach (exps[i]) if (i < i_dev.seq.size()) check(16'(i_dev.seq[i]), 16'(exps[i]));
    for (int a = 0; a <= 3; a++) check({8'h0, i_dev.mem[a]}, {8'h0, (a == waddr && need > 11) ? 8'hff : img[a]});
    check({14'h0, pins.vcc_prog, pins.vpp_prog}, 16'h0);
    $display("test program weak=%0d need=%0d corrupt=%0d done", waddr, need, corrupt);
  endtask : burn_run

  initial begin
    nrst = 1'b0;
    start = 1'b0;
    id_start = 1'b0;
    load_we = 1'b0;
    load_addr = 15'h0;
    load_data = 8'h00;
    wipe = 1'b0;
    corrupt_final = 1'b0;
    weak_addr = 15'h0;
    weak_need = 8'h01;
    bad_count = 0;
    check_count = 0;
    lfsr = 16'hbb55;
    repeat (6) @(posedge clk);
    #1 nrst = 1'b1;
    run(1'b1, {MAKER, DEVICE});
    $display("test identification done");
    burn_run(15'h0, 1, 1'b0);
    burn_run(15'h2, 4, 1'b0);
    burn_run(15'h3, 11, 1'b0);
    burn_run(15'h1, 12, 1'b0);
    burn_run(15'h0, 1, 1'b1);
    results();
  end
endmodule : otp_byte_program_sequencer_tb
